// File: rtl/dbp_pkg.sv
package dbp_pkg;
   // register bus geometry
   localparam int DBP_AW = 8;
   localparam int DBP_DW = 32;
   // register byte offsets
   localparam logic [7:0] DBP_OFF_CTRL     = 8'h00;
   localparam logic [7:0] DBP_OFF_STATUS   = 8'h04;
   localparam logic [7:0] DBP_OFF_IRQ_STAT = 8'h08;
   localparam logic [7:0] DBP_OFF_IRQ_MASK = 8'h0c;
   localparam logic [7:0] DBP_OFF_RX_DATA  = 8'h10;
   localparam logic [7:0] DBP_OFF_TX_DATA  = 8'h14;
   // watch units: address bits [7:5] pick the unit, [4:2] the register
   localparam logic [2:0] DBP_WU_BASE  = 3'h1;
   localparam int         DBP_NUM_WU   = 2;
   localparam logic [2:0] DBP_WREG_AV  = 3'h0;   // address value
   localparam logic [2:0] DBP_WREG_AM  = 3'h1;   // address don't-care mask
   localparam logic [2:0] DBP_WREG_DV  = 3'h2;   // data value
   localparam logic [2:0] DBP_WREG_DM  = 3'h3;   // data don't-care mask
   localparam logic [2:0] DBP_WREG_CTL = 3'h4;   // control compare and enables
   // unit control fields
   localparam int DBP_CTL_W       = 4;
   localparam int DBP_WCTL_MASK_LO = 4;
   localparam int DBP_WCTL_EN     = 8;
   localparam int DBP_WCTL_USE_EXT = 9;
   // debug control bits
   localparam int DBP_CTRL_EXIT  = 0;
   localparam int DBP_CTRL_DBGRQ = 1;
   // status bits
   localparam int DBP_ST_HALT = 0;
   localparam int DBP_ST_PEND = 1;
   localparam int DBP_ST_RX   = 2;
   localparam int DBP_ST_TX   = 3;
   // interrupt sources
   localparam int DBP_IRQ_W       = 4;
   localparam int DBP_IRQ_ENTERED = 0;
   localparam int DBP_IRQ_RX_READ = 1;
   localparam int DBP_IRQ_TX_WORD = 2;
   localparam int DBP_IRQ_WATCH   = 3;
   // pin synchroniser slots
   localparam int DBP_NSYNC   = 8;
   localparam int DBP_SY_EDBG = 0;
   localparam int DBP_SY_DWP  = 1;
   localparam int DBP_SY_IBK  = 2;
   localparam int DBP_SY_EXT0 = 3;
   localparam int DBP_SY_EXT1 = 4;
   localparam int DBP_SY_EN   = 5;
   localparam int DBP_SY_TBE  = 6;
   localparam int DBP_SY_UNI  = 7;
   localparam int DBP_SYNC_LAT = 2;
   // floatable memory-side outputs: both buses, controls, pipeline status, pass
   localparam int DBP_BUS_W = 120;
   // debug state machine
   typedef enum logic [1:0] {DBP_RUN, DBP_PEND, DBP_HALT} dbp_state_t;
endpackage

// File: rtl/dbp_comms_if.sv
`timescale 1ns/1ps
// register-bus side of the comms channel
interface dbp_comms_if;
   import dbp_pkg::*;
   logic              wr_rx;     // host posts a word for the core
   logic [DBP_DW-1:0] wdata;     // posted word
   logic              rd_tx;     // host consumes the core's word
   logic [DBP_DW-1:0] tx_data;   // core's word
   logic              rx_full;   // posted word not yet read by core
   logic              tx_full;   // core's word not yet read by host
   modport host (output wr_rx, wdata, rd_tx, input tx_data, rx_full, tx_full);
   modport chan (input wr_rx, wdata, rd_tx, output tx_data, rx_full, tx_full);
endinterface

// File: rtl/dbp_comms.sv
`timescale 1ns/1ps
module dbp_comms
   import dbp_pkg::*;
(
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              reset,
   // host side
   dbp_comms_if.chan              hif,
   // core side
   input  wire logic              core_rd,
   output logic [DBP_DW-1:0]      core_rd_data,
   input  wire logic              core_wr,
   input  wire logic [DBP_DW-1:0] core_wr_data
);
   logic              rx_full_r;   // receive word waiting
   logic              tx_full_r;   // transmit word waiting
   logic [DBP_DW-1:0] rx_data_r;   // receive word
   logic [DBP_DW-1:0] tx_data_r;   // transmit word

   // receive flag: a new post wins over a core read in the same cycle
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rx_full_r <= 1'b0;
      end else if (hif.wr_rx) begin
         rx_full_r <= 1'b1;
      end else if (core_rd) begin
         rx_full_r <= 1'b0;
      end
   end

   // receive word; a post over an unread word overwrites it
   always_ff @(posedge core_clk) begin
      if (reset) rx_data_r <= '0;
      else if (hif.wr_rx) rx_data_r <= hif.wdata;
   end

   // transmit flag: core write wins over a host read
   always_ff @(posedge core_clk) begin
      if (reset) begin
         tx_full_r <= 1'b0;
      end else if (core_wr) begin
         tx_full_r <= 1'b1;
      end else if (hif.rd_tx) begin
         tx_full_r <= 1'b0;
      end
   end

   // transmit word
   always_ff @(posedge core_clk) begin
      if (reset) tx_data_r <= '0;
      else if (core_wr) tx_data_r <= core_wr_data;
   end

   assign core_rd_data = rx_data_r;
   assign hif.tx_data  = tx_data_r;
   assign hif.rx_full  = rx_full_r;
   assign hif.tx_full  = tx_full_r;

   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   chk_rx_post_sets:  assert property (hif.wr_rx |=> hif.rx_full)
      else $error("rx flag not set by post");
   chk_tx_write_sets: assert property (core_wr |=> hif.tx_full)
      else $error("tx flag not set by core write");
endmodule

// File: rtl/dbp_watch_unit.sv
`timescale 1ns/1ps
module dbp_watch_unit
   import dbp_pkg::*;
(
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 reset,
   // register access
   input  wire logic                 wr_en,
   input  wire logic [2:0]           reg_idx,
   input  wire logic [DBP_DW-1:0]    wdata,
   output logic [DBP_DW-1:0]         rdata,
   // observed buses
   input  wire logic [DBP_DW-1:0]    bus_addr,
   input  wire logic [DBP_DW-1:0]    bus_data,
   input  wire logic [DBP_CTL_W-1:0] bus_ctrl,
   input  wire logic                 ext_cond,
   // results
   output logic                      match,
   output logic                      armed
);
   logic [DBP_DW-1:0] av_r, am_r, dv_r, dm_r, ctl_r;   // compare registers
   logic              a_ok, d_ok, c_ok, e_ok;           // per-field hits

   // configuration registers, written one word at a time
   always_ff @(posedge core_clk) begin
      if (reset) begin
         av_r <= '0; am_r <= '0; dv_r <= '0; dm_r <= '0; ctl_r <= '0;
      end else if (wr_en) begin
         case (reg_idx)
            DBP_WREG_AV:  av_r  <= wdata;
            DBP_WREG_AM:  am_r  <= wdata;
            DBP_WREG_DV:  dv_r  <= wdata;
            DBP_WREG_DM:  dm_r  <= wdata;
            DBP_WREG_CTL: ctl_r <= wdata;
            default:      ;
         endcase
      end
   end

   // read mux; top registers it
   always_comb begin
      case (reg_idx)
         DBP_WREG_AV:  rdata = av_r;
         DBP_WREG_AM:  rdata = am_r;
         DBP_WREG_DV:  rdata = dv_r;
         DBP_WREG_DM:  rdata = dm_r;
         DBP_WREG_CTL: rdata = ctl_r;
         default:      rdata = '0;
      endcase
   end

   // masked compares; a mask bit set means don't care
   assign a_ok  = ((bus_addr ^ av_r) & ~am_r) == '0;
   assign d_ok  = ((bus_data ^ dv_r) & ~dm_r) == '0;
   assign c_ok  = ((bus_ctrl ^ ctl_r[DBP_CTL_W-1:0])
                   & ~ctl_r[DBP_WCTL_MASK_LO +: DBP_CTL_W]) == '0;
   assign e_ok  = ~ctl_r[DBP_WCTL_USE_EXT] | ext_cond;
   // the enable bit is deliberately not part of the match
   assign match = a_ok & d_ok & c_ok & e_ok;
   assign armed = ctl_r[DBP_WCTL_EN];
endmodule

// File: rtl/dbp_debug_pins.sv
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module dbp_debug_pins
   import dbp_pkg::*;
(
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 reset,
   // register port
   input  wire logic [DBP_AW-1:0]    reg_addr,
   input  wire logic [DBP_DW-1:0]    reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic [DBP_DW-1:0]         reg_rdata,
   output logic                      irq,
   // debug pins from outside
   input  wire logic                 external_debug_request,
   input  wire logic                 data_watchpoint_in,
   input  wire logic                 instr_breakpoint_in,
   input  wire logic                 watch_condition_0,
   input  wire logic                 watch_condition_1,
   input  wire logic                 debug_features_enable,
   input  wire logic                 test_bus_drive_enable,
   input  wire logic                 unidirectional_bus_select,
   // debug pins to outside
   output logic                      comms_rx_pending,
   output logic                      comms_tx_free,
   output logic                      debug_state_ack,
   output logic                      core_debug_request,
   output logic                      instruction_executed,
   output logic                      watch_unit0_match,
   output logic                      watch_unit1_match,
   // core pipeline status
   input  wire logic                 instr_mem_req,
   input  wire logic                 data_mem_req,
   input  wire logic                 pipe_advance,
   input  wire logic                 pipe_flush,
   input  wire logic                 exec_valid,
   input  wire logic                 exec_cond_pass,
   input  wire logic                 instr_complete,
   // core buses observed by the watch units
   input  wire logic [DBP_DW-1:0]    bus_addr,
   input  wire logic [DBP_DW-1:0]    bus_data,
   input  wire logic [DBP_CTL_W-1:0] bus_ctrl,
   // core comms access
   input  wire logic                 core_comms_rd,
   output logic [DBP_DW-1:0]         core_comms_rd_data,
   input  wire logic                 core_comms_wr,
   input  wire logic [DBP_DW-1:0]    core_comms_wr_data,
   // floatable memory-side outputs
   input  wire logic [DBP_BUS_W-1:0] core_bus_out,
   output logic [DBP_BUS_W-1:0]      mem_bus_o,
   output logic [DBP_BUS_W-1:0]      mem_bus_oe
);
   // pin synchronisers
   logic [DBP_NSYNC-1:0] pin_raw;    // raw pin levels
   logic [DBP_NSYNC-1:0] sy1_r;      // first stage, read only by second
   logic [DBP_NSYNC-1:0] sy2_r;      // usable levels
   // request cycles delayed to line up with synchronised pins
   logic [DBP_SYNC_LAT-1:0] imreq_d_r;
   logic [DBP_SYNC_LAT-1:0] dmreq_d_r;
   // control and state
   dbp_state_t           state_r, state_nxt;   // debug state machine
   logic                 ctrl_rq_r;            // software debug request bit
   logic                 exit_req;             // software leave-debug pulse
   logic                 tag_fetch_r;          // breakpoint tag at fetch
   logic                 tag_exec_r;           // breakpoint tag at execute
   logic                 iexec_r;              // executed flag
   logic                 dbg_en;               // synchronised enable
   logic                 dwp_hit, ibk_hit, wu_hit;
   // interrupt block
   logic [DBP_IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_ev;
   // register bus
   logic [DBP_DW-1:0]    rdata_r, rd_mux;
   logic                 hit_ctrl, hit_stat, hit_irqs, hit_irqm, hit_rx, hit_tx;
   // watch units
   logic [DBP_NUM_WU-1:0] wu_match, wu_armed, wu_ext, wu_sel;
   logic [DBP_DW-1:0]     wu_rdata [DBP_NUM_WU];
   logic                  bus_drive;
   dbp_comms_if           cif ();

   // pins enter through two flip-flops
   assign pin_raw = {unidirectional_bus_select, test_bus_drive_enable,
                     debug_features_enable, watch_condition_1, watch_condition_0,
                     instr_breakpoint_in, data_watchpoint_in, external_debug_request};
   genvar gi;
   for (gi = 0; gi < DBP_NSYNC; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
         if (reset) begin
            sy1_r[gi] <= 1'b0;
            sy2_r[gi] <= 1'b0;
         end else begin
            sy1_r[gi] <= pin_raw[gi];
            sy2_r[gi] <= sy1_r[gi];
         end
      end
   end
   assign dbg_en = sy2_r[DBP_SY_EN];

   // phase one ends on the rising edge, where the pins are sampled;
   // the request flags are delayed by the synchroniser depth so a pin
   // is judged against the request cycle it followed
   always_ff @(posedge core_clk) begin
      if (reset) begin
         imreq_d_r <= '0;
         dmreq_d_r <= '0;
      end else begin
         imreq_d_r <= {imreq_d_r[DBP_SYNC_LAT-2:0], instr_mem_req};
         dmreq_d_r <= {dmreq_d_r[DBP_SYNC_LAT-2:0], data_mem_req};
      end
   end

   // register decode
   assign hit_ctrl = reg_addr == DBP_OFF_CTRL;
   assign hit_stat = reg_addr == DBP_OFF_STATUS;
   assign hit_irqs = reg_addr == DBP_OFF_IRQ_STAT;
   assign hit_irqm = reg_addr == DBP_OFF_IRQ_MASK;
   assign hit_rx   = reg_addr == DBP_OFF_RX_DATA;
   assign hit_tx   = reg_addr == DBP_OFF_TX_DATA;
   assign exit_req = reg_wr & hit_ctrl & reg_wdata[DBP_CTRL_EXIT];

   // watch units, one per generate entry
   assign wu_ext = {sy2_r[DBP_SY_EXT1], sy2_r[DBP_SY_EXT0]};
   for (gi = 0; gi < DBP_NUM_WU; gi++) begin : g_wu
      assign wu_sel[gi] = reg_addr[7:5] == DBP_WU_BASE + 3'(gi);
      dbp_watch_unit u_wu (
         .core_clk (core_clk),
         .reset    (reset),
         .wr_en    (reg_wr & wu_sel[gi]),
         .reg_idx  (reg_addr[4:2]),
         .wdata    (reg_wdata),
         .rdata    (wu_rdata[gi]),
         .bus_addr (bus_addr),
         .bus_data (bus_data),
         .bus_ctrl (bus_ctrl),
         .ext_cond (wu_ext[gi]),
         .match    (wu_match[gi]),
         .armed    (wu_armed[gi])
      );
   end
   // range outputs follow the compare, gated only by the global enable
   assign watch_unit0_match = dbg_en & wu_match[0];
   assign watch_unit1_match = dbg_en & wu_match[1];

   // comms channel
   assign cif.wr_rx = reg_wr & hit_rx;
   assign cif.wdata = reg_wdata;
   assign cif.rd_tx = reg_rd & hit_tx;
   dbp_comms u_comms (
      .core_clk     (core_clk),
      .reset        (reset),
      .hif          (cif.chan),
      .core_rd      (core_comms_rd),
      .core_rd_data (core_comms_rd_data),
      .core_wr      (core_comms_wr),
      .core_wr_data (core_comms_wr_data)
   );
   assign comms_rx_pending = cif.rx_full;
   assign comms_tx_free    = ~cif.tx_full;

   // software debug request bit
   always_ff @(posedge core_clk) begin
      if (reset) ctrl_rq_r <= 1'b0;
      else if (reg_wr & hit_ctrl) ctrl_rq_r <= reg_wdata[DBP_CTRL_DBGRQ];
   end
   // the request the core sees; the debugger holds it until acknowledged
   assign core_debug_request = dbg_en & (sy2_r[DBP_SY_EDBG] | ctrl_rq_r);

   // halting causes
   assign dwp_hit = dbg_en & sy2_r[DBP_SY_DWP] & dmreq_d_r[DBP_SYNC_LAT-1];
   assign wu_hit  = dbg_en & |(wu_match & wu_armed);
   assign ibk_hit = dbg_en & tag_exec_r & exec_valid;

   // breakpoint tag rides with the fetch; one fetch in flight per stage,
   // a flush drops it so a cancelled fetch never halts
   always_ff @(posedge core_clk) begin
      if (reset | pipe_flush | ~dbg_en) begin
         tag_fetch_r <= 1'b0;
         tag_exec_r  <= 1'b0;
      end else begin
         if (sy2_r[DBP_SY_IBK] & imreq_d_r[DBP_SYNC_LAT-1]) begin
            tag_fetch_r <= 1'b1;
         end else if (pipe_advance) begin
            tag_fetch_r <= 1'b0;
         end
         if (pipe_advance) tag_exec_r <= tag_fetch_r;
         else if (exec_valid) tag_exec_r <= 1'b0;
      end
   end

   // debug state machine
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         DBP_RUN: begin
            if (dwp_hit | ibk_hit | wu_hit) state_nxt = DBP_HALT;
            else if (core_debug_request) state_nxt = DBP_PEND;
         end
         DBP_PEND: begin
            // wait for the executing instruction to finish
            if (dwp_hit | ibk_hit | wu_hit | instr_complete) state_nxt = DBP_HALT;
         end
         DBP_HALT: begin
            if (exit_req) state_nxt = DBP_RUN;
         end
         default: state_nxt = DBP_RUN;
      endcase
      if (!dbg_en) state_nxt = DBP_RUN;
   end
   always_ff @(posedge core_clk) begin
      if (reset) state_r <= DBP_RUN;
      else state_r <= state_nxt;
   end
   assign debug_state_ack = state_r == DBP_HALT;

   // executed flag, one cycle behind the execute stage
   always_ff @(posedge core_clk) begin
      if (reset) iexec_r <= 1'b0;
      else iexec_r <= exec_valid & exec_cond_pass;
   end
   assign instruction_executed = iexec_r;

   // interrupt events; a set in the read cycle survives the clear
   assign irq_ev[DBP_IRQ_ENTERED] = state_nxt == DBP_HALT && state_r != DBP_HALT;
   assign irq_ev[DBP_IRQ_RX_READ] = core_comms_rd & cif.rx_full;
   assign irq_ev[DBP_IRQ_TX_WORD] = core_comms_wr;
   assign irq_ev[DBP_IRQ_WATCH]   = |{watch_unit1_match, watch_unit0_match};
   always_ff @(posedge core_clk) begin
      if (reset) irq_stat_r <= '0;
      else if (reg_rd & hit_irqs) irq_stat_r <= irq_ev;
      else irq_stat_r <= irq_stat_r | irq_ev;
   end
   always_ff @(posedge core_clk) begin
      if (reset) irq_mask_r <= '0;
      else if (reg_wr & hit_irqm) irq_mask_r <= reg_wdata[DBP_IRQ_W-1:0];
   end
   assign irq = |(irq_stat_r & irq_mask_r);

   // read mux; unmapped addresses read zero
   always_comb begin
      rd_mux = '0;
      if (hit_ctrl) rd_mux[DBP_CTRL_DBGRQ] = ctrl_rq_r;
      else if (hit_stat) begin
         rd_mux[DBP_ST_HALT] = state_r == DBP_HALT;
         rd_mux[DBP_ST_PEND] = state_r == DBP_PEND;
         rd_mux[DBP_ST_RX]   = cif.rx_full;
         rd_mux[DBP_ST_TX]   = cif.tx_full;
      end
      else if (hit_irqs) rd_mux[DBP_IRQ_W-1:0] = irq_stat_r;
      else if (hit_irqm) rd_mux[DBP_IRQ_W-1:0] = irq_mask_r;
      else if (hit_tx)   rd_mux = cif.tx_data;
      else if (wu_sel[0]) rd_mux = wu_rdata[0];
      else if (wu_sel[1]) rd_mux = wu_rdata[1];
   end
   // read data stand for exactly the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (reset) rdata_r <= '0;
      else rdata_r <= reg_rd ? rd_mux : '0;
   end
   assign reg_rdata = rdata_r;

   // memory-side outputs: data registered, enables from synchronised pins
   always_ff @(posedge core_clk) begin
      if (reset) mem_bus_o <= '0;
      else mem_bus_o <= core_bus_out;
   end
   // test bus enable floats the bus unless unidirectional mode holds it
   assign bus_drive  = sy2_r[DBP_SY_UNI] | sy2_r[DBP_SY_TBE];
   assign mem_bus_oe = {DBP_BUS_W{bus_drive}};

   // checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   chk_ack_needs_enable: assert property (debug_state_ack |-> $past(dbg_en))
      else $error("debug state entered while disabled");
   chk_ack_holds_state: assert property (debug_state_ack && !exit_req && dbg_en
                                         |=> debug_state_ack)
      else $error("acknowledge dropped without exit");
   chk_request_from_ctrl: assert property ($rose(ctrl_rq_r) && dbg_en
                                           |-> core_debug_request)
      else $error("control bit did not raise request");
   chk_dwatch_halts: assert property (dwp_hit |=> debug_state_ack)
      else $error("data watchpoint did not halt");
   chk_request_waits: assert property (state_r == DBP_PEND && !instr_complete
                                       && !dwp_hit && !ibk_hit && !wu_hit
                                       |=> !debug_state_ack)
      else $error("halted before instruction completed");
   chk_tag_exec_halts: assert property (ibk_hit |=> debug_state_ack)
      else $error("tagged instruction did not halt");
   chk_exec_flag_lag: assert property (##1 instruction_executed
                                       == $past(exec_valid && exec_cond_pass))
      else $error("executed flag mismatch");
   chk_tbe_floats: assert property (!sy2_r[DBP_SY_UNI] && !sy2_r[DBP_SY_TBE]
                                    |-> mem_bus_oe == '0)
      else $error("bus driven while test bus disabled");
   chk_unidir_drives: assert property (sy2_r[DBP_SY_UNI] |-> &mem_bus_oe)
      else $error("bus floated in unidirectional mode");
   chk_rx_flag_pin: assert property (cif.wr_rx |=> comms_rx_pending)
      else $error("rx pending not raised");
endmodule

// File: tb/dbp_debugger_model.sv
`timescale 1ns/1ps
// debug probe on the far side: raises a halt request and keeps it up until acknowledged
module dbp_debugger_model (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   // bench command and device answer
   input  wire logic go,
   input  wire logic debug_state_ack,
   // request pin
   output logic      external_debug_request
);
   // dropping early could lose the halt, so release only once ack is seen
   always_ff @(posedge core_clk) begin
      if (reset) begin
         external_debug_request <= 1'b0;
      end else if (go) begin
         external_debug_request <= 1'b1;
      end else if (debug_state_ack) begin
         external_debug_request <= 1'b0;
      end
   end
endmodule

// File: tb/debug_entry_and_status_pins_tb.sv
`timescale 1ns/1ps
module debug_entry_and_status_pins_tb;
   import dbp_pkg::*;
   // pins, buses and bench state
   logic core_clk, reset, reg_wr, reg_rd, irq, go, external_debug_request, data_watchpoint_in;
   logic instr_breakpoint_in, watch_condition_0, watch_condition_1, debug_features_enable;
   logic test_bus_drive_enable, unidirectional_bus_select, comms_rx_pending, comms_tx_free;
   logic debug_state_ack, core_debug_request, instruction_executed, watch_unit0_match;
   logic watch_unit1_match, instr_mem_req, data_mem_req, pipe_advance, pipe_flush, exec_valid;
   logic exec_cond_pass, instr_complete, core_comms_rd, core_comms_wr, v, p;
   logic [7:0]            reg_addr;
   logic [DBP_DW-1:0]     reg_wdata, reg_rdata, bus_addr, bus_data, d, core_comms_rd_data;
   logic [DBP_DW-1:0]     core_comms_wr_data;
   logic [DBP_CTL_W-1:0]  bus_ctrl;
   logic [DBP_BUS_W-1:0]  core_bus_out, mem_bus_o, mem_bus_oe;
   int                    err_count, tests_run;
   dbp_debug_pins dbp_debug_pins_i (.*);
   dbp_debugger_model dbp_debugger_model_i (.*);
   // free running core clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("tests %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // let n edges pass, then sample after updates land
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] w);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= w;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   // bounded wait on the acknowledge level
   task automatic waitack(input logic e);
      for (int i = 0; i < 20 && debug_state_ack !== e; i++) cyc(1);
      chk(debug_state_ack, e);
      if (debug_state_ack !== e) end_of_test();
   endtask
   initial begin
      {reg_wr, reg_rd, go, data_watchpoint_in, instr_breakpoint_in, watch_condition_0} = '0;
      {watch_condition_1, unidirectional_bus_select, instr_mem_req, data_mem_req} = '0;
      {pipe_advance, pipe_flush, exec_valid, exec_cond_pass, instr_complete} = '0;
      {core_comms_rd, core_comms_wr, reg_addr, reg_wdata, bus_data} = '0;
      // units reset to compare against address zero; keep the idle bus off it
      bus_addr = 32'h1;
      {core_comms_wr_data, bus_ctrl, core_bus_out, err_count, tests_run} = '0;
      {debug_features_enable, test_bus_drive_enable} = 2'b11;
      void'($urandom(18690));
      reset = 1'b1;
      cyc(20);
      reset <= 1'b0;
      cyc(3);
      chk(comms_tx_free, 1);
      chk({comms_rx_pending, debug_state_ack}, 0);
      // bus float and its override
      test_bus_drive_enable <= 1'b0;
      cyc(4);
      chk(|mem_bus_oe, 0);
      unidirectional_bus_select <= 1'b1;
      core_bus_out <= '1;
      cyc(4);
      chk(&mem_bus_oe, 1);
      chk(&mem_bus_o, 1);
      {unidirectional_bus_select, test_bus_drive_enable} <= 2'b01;
      // comms channel both ways
      d = $urandom;
      wr(DBP_OFF_RX_DATA, d);
      cyc(1);
      chk(comms_rx_pending, 1);
      chk(core_comms_rd_data, d);
      core_comms_rd <= 1'b1;
      cyc(1);
      core_comms_rd <= 1'b0;
      cyc(1);
      chk(comms_rx_pending, 0);
      core_comms_wr <= 1'b1;
      core_comms_wr_data <= d;
      cyc(1);
      core_comms_wr <= 1'b0;
      cyc(1);
      chk(comms_tx_free, 0);
      rd(DBP_OFF_TX_DATA, d);
      cyc(1);
      chk(comms_tx_free, 1);
      // masked events stay silent, read clears them
      wr(DBP_OFF_IRQ_MASK, 32'h1);
      cyc(1);
      chk(irq, 0);
      rd(DBP_OFF_IRQ_STAT, 32'h6);
      // halt by request waits for the current instruction
      go <= 1'b1;
      cyc(1);
      go <= 1'b0;
      cyc(4);
      chk({core_debug_request, debug_state_ack}, 2);
      instr_complete <= 1'b1;
      cyc(1);
      instr_complete <= 1'b0;
      waitack(1);
      chk(irq, 1);
      rd(DBP_OFF_IRQ_STAT, 32'h1);
      chk(irq, 0);
      wr(DBP_OFF_CTRL, 32'h1);
      waitack(0);
      // data watchpoint after a data request
      {data_mem_req, data_watchpoint_in} <= 2'b11;
      cyc(1);
      {data_mem_req, data_watchpoint_in} <= 2'b00;
      waitack(1);
      wr(DBP_OFF_CTRL, 32'h1);
      waitack(0);
      // executed flag follows the previous cycle
      for (int i = 0; i < 16; i++) begin
         {v, p} = 2'($urandom);
         exec_valid <= v;
         exec_cond_pass <= p;
         cyc(1);
         chk(instruction_executed, v & p);
      end
      exec_valid <= 1'b0;
      // unit 0 compares address and condition 0, unit 1 only condition 1
      wr(8'h20, d);
      wr(8'h24, 32'h0);
      wr(8'h2c, 32'hffffffff);
      wr(8'h30, 32'h200);
      wr(8'h44, 32'hffffffff);
      wr(8'h4c, 32'hffffffff);
      wr(8'h50, 32'h200);
      for (int i = 0; i < 12; i++) begin
         bus_addr <= ($urandom % 2) ? d : $urandom;
         bus_data <= $urandom;
         watch_condition_0 <= 1'($urandom);
         watch_condition_1 <= 1'($urandom);
         cyc(3);
         chk({watch_unit0_match, watch_unit1_match},
             {bus_addr == d && watch_condition_0, watch_condition_1});
      end
      // control bit request, then the enable pin drops request, watch match and acknowledge
      wr(DBP_OFF_CTRL, 32'h2);
      cyc(1);
      chk(core_debug_request, 1);
      debug_features_enable <= 1'b0;
      bus_addr <= d;
      cyc(4);
      chk({core_debug_request, watch_unit0_match, debug_state_ack}, 0);
      end_of_test();
   end
endmodule
